/* File: src/acip_pkg.sv */
package acip_pkg;

  // Bus address and byte framing
  localparam logic [6:0] ACIP_TARGET_BUS_ADDRESS = 7'h0f;
  localparam logic [3:0] ACIP_BYTE_BITS = 4'h8;
  localparam logic [3:0] ACIP_LAST_TX_BIT = 4'h7;
  localparam logic [3:0] ACIP_CNT_ZERO = 4'h0;
  localparam logic [3:0] ACIP_CNT_ONE = 4'h1;
  localparam logic [7:0] ACIP_PTR_STEP = 8'h01;
  localparam logic [7:0] ACIP_PTR_RESET = 8'h00;
  localparam logic [7:0] ACIP_BYTE_RESET = 8'h00;

  // Writable register address spans
  localparam logic [7:0] ACIP_FIRST_CONTROL_REGISTER = 8'h1b;
  localparam logic [7:0] ACIP_CONTROL_SPAN_LAST = 8'h21;
  localparam logic [7:0] ACIP_TIMER_SPAN_FIRST = 8'h28;
  localparam logic [7:0] ACIP_TIMER_SPAN_LAST = 8'h29;
  localparam logic [7:0] ACIP_TAP_SPAN_FIRST = 8'h2b;
  localparam logic [7:0] ACIP_TAP_SPAN_LAST = 8'h33;
  localparam logic [7:0] ACIP_BUF_FLUSH_REG = 8'h36;
  localparam logic [7:0] ACIP_SELF_CHECK_REG = 8'h3a;
  localparam logic [7:0] ACIP_WAKE_LEVEL_REG = 8'h5a;
  localparam logic [7:0] ACIP_TILT_LIMIT_REG = 8'h5c;
  localparam logic [7:0] ACIP_HYST_REG = 8'h5f;

  // Write buffer
  localparam int ACIP_BUF_DEPTH = 2;
  localparam logic [1:0] ACIP_BUF_FULL = 2'h2;
  localparam logic [1:0] ACIP_BUF_EMPTY = 2'h0;
  localparam logic [1:0] ACIP_BUF_ONE = 2'h1;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } acip_wr_t;

  typedef enum logic [2:0] {
    ACIP_IDLE = 3'b000,
    ACIP_RX = 3'b001,
    ACIP_ACK = 3'b010,
    ACIP_FETCH = 3'b011,
    ACIP_TX = 3'b100,
    ACIP_MACK = 3'b101
  } acip_state_t;

  typedef enum logic [1:0] {
    ACIP_ROLE_ADDR = 2'b00,
    ACIP_ROLE_PTR = 2'b01,
    ACIP_ROLE_DATA = 2'b10
  } acip_role_t;

  function automatic logic acip_writable(input logic [7:0] a);
    acip_writable = (a >= ACIP_FIRST_CONTROL_REGISTER && a <= ACIP_CONTROL_SPAN_LAST)
      || (a >= ACIP_TIMER_SPAN_FIRST && a <= ACIP_TIMER_SPAN_LAST)
      || (a >= ACIP_TAP_SPAN_FIRST && a <= ACIP_TAP_SPAN_LAST)
      || a == ACIP_BUF_FLUSH_REG || a == ACIP_SELF_CHECK_REG
      || a == ACIP_WAKE_LEVEL_REG || a == ACIP_TILT_LIMIT_REG || a == ACIP_HYST_REG;
  endfunction

endpackage

/* File: src/acip_target.sv */
`timescale 1ns/1ps
module acip_target
  import acip_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Serial clock pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_b,
  // Serial data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_b,
  // Register write stream
  output logic wr_valid,
  input wire logic wr_ready,
  output acip_wr_t wr_word,
  // Register read request
  output logic rd_req,
  output logic [7:0] rd_addr,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  // Status
  output logic bus_busy
);

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  acip_state_t state_q;
  acip_role_t role_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] register_pointer_q;
  logic read_q;
  logic hold_q;
  logic mack_q;
  logic busy_q;
  logic sda_oe_b_q;
  logic scl_oe_b_q;
  logic tx_load_q;

  acip_wr_t buf_q [ACIP_BUF_DEPTH];
  logic wp_q;
  logic rp_q;
  logic [1:0] fill_q;
  logic buf_full;
  logic push;
  logic pop;

  // Pin synchronisers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  assign start_seen = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_seen = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  // Bus busy tracking
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      busy_q <= 1'b0;
    end
    else if (start_seen)
    begin
      busy_q <= 1'b1;
    end
    else if (stop_seen || (scl_s && sda_s && state_q == ACIP_IDLE))
    begin
      busy_q <= 1'b0;
    end
  end

  // Protocol engine
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_q <= ACIP_IDLE;
      role_q <= ACIP_ROLE_ADDR;
      cnt_q <= ACIP_CNT_ZERO;
      shift_q <= ACIP_BYTE_RESET;
      register_pointer_q <= ACIP_PTR_RESET;
      read_q <= 1'b0;
      hold_q <= 1'b0;
      mack_q <= 1'b0;
    end
    else if (start_seen)
    begin
      // Start or repeated start; pointer is kept
      state_q <= ACIP_RX;
      role_q <= ACIP_ROLE_ADDR;
      cnt_q <= ACIP_CNT_ZERO;
      hold_q <= 1'b0;
    end
    else if (stop_seen)
    begin
      state_q <= ACIP_IDLE;
      hold_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ACIP_IDLE:
        begin
          cnt_q <= ACIP_CNT_ZERO;
        end
        ACIP_RX:
        begin
          if (scl_rise)
          begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q <= cnt_q + ACIP_CNT_ONE;
          end
          else if (scl_fall && cnt_q == ACIP_BYTE_BITS)
          begin
            unique case (role_q)
              ACIP_ROLE_ADDR:
              begin
                if (shift_q[7:1] == ACIP_TARGET_BUS_ADDRESS)
                begin
                  read_q <= shift_q[0];
                  state_q <= ACIP_ACK;
                end
                else
                begin
                  state_q <= ACIP_IDLE;
                end
              end
              ACIP_ROLE_PTR:
              begin
                register_pointer_q <= shift_q;
                state_q <= ACIP_ACK;
              end
              default:
              begin
                hold_q <= acip_writable(register_pointer_q);
                state_q <= ACIP_ACK;
              end
            endcase
          end
        end
        ACIP_ACK:
        begin
          if (hold_q)
          begin
            if (push)
            begin
              hold_q <= 1'b0;
            end
          end
          else if (scl_fall)
          begin
            cnt_q <= ACIP_CNT_ZERO;
            unique case (role_q)
              ACIP_ROLE_ADDR:
              begin
                role_q <= ACIP_ROLE_PTR;
              end
              ACIP_ROLE_PTR:
              begin
                role_q <= ACIP_ROLE_DATA;
              end
              default:
              begin
                register_pointer_q <= register_pointer_q + ACIP_PTR_STEP;
              end
            endcase
            state_q <= read_q ? ACIP_FETCH : ACIP_RX;
          end
        end
        ACIP_FETCH:
        begin
          if (rd_valid)
          begin
            shift_q <= rd_data;
            register_pointer_q <= register_pointer_q + ACIP_PTR_STEP;
            cnt_q <= ACIP_CNT_ZERO;
            state_q <= ACIP_TX;
          end
        end
        ACIP_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_q == ACIP_LAST_TX_BIT)
            begin
              state_q <= ACIP_MACK;
            end
            else
            begin
              shift_q <= {shift_q[6:0], 1'b0};
              cnt_q <= cnt_q + ACIP_CNT_ONE;
            end
          end
        end
        ACIP_MACK:
        begin
          if (scl_rise)
          begin
            mack_q <= !sda_s;
          end
          else if (scl_fall)
          begin
            state_q <= mack_q ? ACIP_FETCH : ACIP_IDLE;
          end
        end
        default:
        begin
          state_q <= ACIP_IDLE;
        end
      endcase
    end
  end

  // Pin drive, only ever pulling low
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      sda_oe_b_q <= 1'b1;
      scl_oe_b_q <= 1'b1;
      tx_load_q <= 1'b0;
    end
    else
    begin
      sda_oe_b_q <= !(state_q == ACIP_ACK || (state_q == ACIP_TX && !shift_q[7]));
      // First bit settles before SCL is let go
      tx_load_q <= (state_q == ACIP_FETCH);
      scl_oe_b_q <= !((state_q == ACIP_ACK && hold_q) || state_q == ACIP_FETCH
        || tx_load_q);
    end
  end

  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe_b = sda_oe_b_q;
  assign scl_oe_b = scl_oe_b_q;
  assign bus_busy = busy_q;

  // Read request
  assign rd_req = (state_q == ACIP_FETCH);
  assign rd_addr = register_pointer_q;

  // Two-entry write buffer
  assign buf_full = (fill_q == ACIP_BUF_FULL);
  assign push = (state_q == ACIP_ACK) && hold_q && !buf_full;
  assign wr_valid = (fill_q != ACIP_BUF_EMPTY);
  assign pop = wr_valid && wr_ready;
  assign wr_word = buf_q[rp_q];

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      fill_q <= ACIP_BUF_EMPTY;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        buf_q[wp_q] <= '{addr: register_pointer_q, data: shift_q};
        wp_q <= !wp_q;
      end
      if (pop)
      begin
        rp_q <= !rp_q;
      end
      if (push && !pop)
      begin
        fill_q <= fill_q + ACIP_BUF_ONE;
      end
      else if (pop && !push)
      begin
        fill_q <= fill_q - ACIP_BUF_ONE;
      end
    end
  end

endmodule

/* File: tb/acip_target_sva.sv */
`timescale 1ns/1ps
module acip_target_sva
  import acip_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_o,
  input wire logic scl_oe_b,
  input wire logic sda_o,
  input wire logic sda_oe_b,
  // Write and read sides
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire acip_wr_t wr_word,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic [7:0] rd_addr,
  input wire logic bus_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_start;
    $fell(sda_i) && scl_i;
  endsequence
  sequence s_stop;
    $rose(sda_i) && scl_i;
  endsequence
  property p_low_only;
    scl_o == 1'b0 && sda_o == 1'b0;
  endproperty
  property p_stretch;
    $fell(scl_oe_b) |-> !$past(scl_i);
  endproperty
  property p_fetch;
    rd_req && $past(rd_req) |-> !scl_oe_b;
  endproperty
  property p_rd_done;
    rd_req && rd_valid |=> !rd_req && rd_addr == $past(rd_addr) + ACIP_PTR_STEP;
  endproperty
  property p_rd_wait;
    rd_req && !rd_valid |=> rd_req && $stable(rd_addr);
  endproperty
  property p_wr_hold;
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_word);
  endproperty
  property p_start;
    s_start |-> ##[1:6] bus_busy;
  endproperty
  property p_stop;
    s_stop |-> ##[1:6] !bus_busy;
  endproperty
  property p_steady;
    $changed(sda_oe_b) |-> !scl_i;
  endproperty
  property p_release;
    $fell(bus_busy) |-> sda_oe_b && scl_oe_b;
  endproperty
  a_low_only: assert property (p_low_only) else $error("pin driven high");
  a_stretch: assert property (p_stretch) else $error("stretch in high");
  a_fetch: assert property (p_fetch) else $error("no stretch in fetch");
  a_rd_done: assert property (p_rd_done) else $error("read step wrong");
  a_rd_wait: assert property (p_rd_wait) else $error("read request lost");
  a_wr_hold: assert property (p_wr_hold) else $error("word lost");
  a_start: assert property (p_start) else $error("start missed");
  a_stop: assert property (p_stop) else $error("stop missed");
  a_steady: assert property (p_steady) else $error("sda moved in high");
  a_release: assert property (p_release) else $error("lines held");
endmodule

/* File: tb/acip_master.sv */
`timescale 1ns/1ps
module acip_master (
  // Wired bus levels
  input wire logic scl_ln,
  input wire logic sda_ln,
  // Drive, low pulls the line
  output logic scl_m,
  output logic sda_m
);
  initial
  begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  task automatic strt();
    #16 sda_m = 1'b1;
    #16 scl_m = 1'b1;
    #32 sda_m = 1'b0;
    #32 scl_m = 1'b0;
  endtask
  task automatic stp();
    #16 sda_m = 1'b0;
    #16 scl_m = 1'b1;
    wait (scl_ln === 1'b1);
    #32 sda_m = 1'b1;
    #64;
  endtask
  task automatic xb(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
    output logic ak);
    logic [8:0] sh;
    sh = {tx, ai};
    for (int i = 8; i >= 0; i--)
    begin
      #16 sda_m = sh[i];
      #16 scl_m = 1'b1;
      wait (scl_ln === 1'b1);
      #32 sh[i] = sda_ln;
      scl_m = 1'b0;
    end
    {rx, ak} = sh;
  endtask
endmodule

/* File: tb/acip_target_tb.sv */
`timescale 1ns/1ps
module acip_target_tb;
  import acip_pkg::*;
  typedef struct packed {
    logic [6:0] a;
    logic [7:0] p;
    logic [7:0] d;
    logic ak;
    logic push;
  } acip_row_t;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr_ready = 1'b0;
  logic rd_valid = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic slow = 1'b0;
  logic scl_o, scl_oe_b, sda_o, sda_oe_b, scl_m, sda_m;
  logic wr_valid, rd_req, bus_busy, ak;
  logic [7:0] rd_addr, rx;
  acip_wr_t wr_word;
  acip_wr_t got[$];
  wire logic scl_ln = scl_m & (scl_oe_b | scl_o);
  wire logic sda_ln = sda_m & (sda_oe_b | sda_o);
  int error_cnt = 0;
  int tests_run = 0;
  acip_row_t rows[5] = '{
    '{7'h0f, 8'h1b, 8'h00, 1'b0, 1'b1},
    '{7'h0f, 8'h5f, 8'hc3, 1'b0, 1'b1},
    '{7'h0f, 8'h10, 8'h3c, 1'b0, 1'b0},
    '{7'h0e, 8'h1c, 8'h5a, 1'b1, 1'b0},
    '{7'h4f, 8'h36, 8'h81, 1'b1, 1'b0}};
  always #2.5 ref_clk = ~ref_clk;
  acip_target DUT (.ref_clk(ref_clk), .rst_b(rst_b), .scl_i(scl_ln), .scl_o(scl_o),
    .scl_oe_b(scl_oe_b), .sda_i(sda_ln), .sda_o(sda_o), .sda_oe_b(sda_oe_b),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .bus_busy(bus_busy));
  acip_master MST (.scl_ln(scl_ln), .sda_ln(sda_ln), .scl_m(scl_m), .sda_m(sda_m));
  // Register file side
  always @(posedge ref_clk)
  begin
    wr_ready <= !slow;
    rd_valid <= rd_req && !rd_valid;
    rd_data <= rd_addr ^ 8'h5a;
    if (wr_valid && wr_ready)
      got.push_back(wr_word);
  end
  task automatic chk(input logic [15:0] a, input logic [15:0] e);
    tests_run++;
    if (a !== e)
    begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, a, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input int n,
    input logic [7:0] d, output logic aa);
    logic b;
    MST.strt();
    MST.xb({a, 1'b0}, 1'b1, rx, aa);
    MST.xb(p, 1'b1, rx, b);
    chk(b, aa);
    for (int i = 0; i < n; i++)
    begin
      MST.xb(d + i[7:0], 1'b1, rx, b);
      chk(b, aa);
    end
    MST.stp();
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    MST.strt();
    MST.xb({ACIP_TARGET_BUS_ADDRESS, 1'b0}, 1'b1, rx, ak);
    MST.xb(p, 1'b1, rx, ak);
    MST.strt();
    MST.xb({ACIP_TARGET_BUS_ADDRESS, 1'b1}, 1'b1, rx, ak);
    chk(ak, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      MST.xb(8'hff, i == n - 1, rx, ak);
      chk(rx, (p + i[7:0]) ^ 8'h5a);
    end
    MST.stp();
  endtask
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    chk({scl_oe_b, sda_oe_b, wr_valid, rd_req, bus_busy}, 5'h18);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    $display("reset test done");
    foreach (rows[k])
    begin
      got.delete();
      wr(rows[k].a, rows[k].p, 1, rows[k].d, ak);
      chk(ak, rows[k].ak);
      chk(16'(got.size()), rows[k].push);
      chk(bus_busy, 1'b0);
      if (rows[k].push)
        chk(got[0], {rows[k].p, rows[k].d});
      $display("row %0d done", k);
    end
    got.delete();
    slow = 1'b1;
    fork
      wr(ACIP_TARGET_BUS_ADDRESS, 8'h2b, 4, 8'h10, ak);
      begin
        repeat (1000) @(posedge ref_clk);
        chk(scl_oe_b, 1'b0);
        chk(16'(got.size()), 16'h0000);
        slow = 1'b0;
      end
    join
    chk(16'(got.size()), 16'h0004);
    for (int i = 0; i < 4; i++)
      chk(got[i], {8'h2b + i[7:0], 8'h10 + i[7:0]});
    $display("stall test done");
    rd(8'h7e, 3);
    rd(8'h1b, 1);
    $display("read test done");
    rst_b <= 1'b0;
    repeat (20) @(posedge ref_clk);
    chk({scl_oe_b, sda_oe_b, wr_valid, rd_req, bus_busy}, 5'h18);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    MST.strt();
    MST.xb({ACIP_TARGET_BUS_ADDRESS, 1'b1}, 1'b1, rx, ak);
    chk(ak, 1'b0);
    MST.xb(8'hff, 1'b1, rx, ak);
    chk(rx, ACIP_PTR_RESET ^ 8'h5a);
    MST.stp();
    chk(bus_busy, 1'b0);
    $display("mid reset test done");
    end_of_test();
  end
  initial
  begin
    #200000;
    error_cnt++;
    end_of_test();
  end
endmodule
bind acip_target acip_target_sva SVA (.ref_clk(ref_clk), .rst_b(rst_b), .scl_i(scl_i),
  .sda_i(sda_i), .scl_o(scl_o), .scl_oe_b(scl_oe_b), .sda_o(sda_o),
  .sda_oe_b(sda_oe_b), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
  .rd_req(rd_req), .rd_valid(rd_valid), .rd_addr(rd_addr), .bus_busy(bus_busy));
